// [logic/glic_top.sv]
/*
 GPIO expander slice: direction, pull-up, output data, table-driven line 4, edge detection with mask,
 sticky source and event flags, optional auto-clear on data read, open-drain interrupt.
 Assumes pad inputs and I2C pins are synchronous to clk_i; pads resolve drive from the enables.
*/
`timescale 1ns/1ps
`include "glic_params.svh"

// Behaviour
// - logic mode: line 4 from table bit indexed by lines 2:0
// - auto-clear off: flags stay until host clears
// - auto-clear on: data read clears source flags
// - direction one is input, pull-up one enables
// - mask zero enables; sense 10 means falling
// - unmasked edge sets flag, pulls interrupt low
// - writing ones to source clears flags
module glic_top #(
	parameter logic [6:0] DEV_ADDR = `GLIC_I2C_ADDR,
	parameter int         LINES    = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             scl_i,
	input  wire logic             sda_i,
	output logic                  sda_o,
	output logic                  sda_oe_n_o,
	input  wire logic [LINES-1:0] pad_in_i,
	output logic [LINES-1:0]      pad_out_o,
	output logic [LINES-1:0]      pad_oe_n_o,
	output logic [LINES-1:0]      pull_en_o,
	output logic                  irq_out_n_o,
	output logic                  irq_out_n_oe_n_o
);
	import glic_pkg::*;

	glic_req_s        req;
	logic [7:0]       rdata;
	logic [LINES-1:0] dir_r, dir_nxt, pull_r, pull_nxt, mask_r, mask_nxt;
	logic [LINES-1:0] data_r, data_nxt, src_r, src_nxt, evt_r, evt_nxt, prev_r, prev_nxt;
	logic [2*LINES-1:0] sense_r, sense_nxt;
	logic [7:0]       lut4_r, lut4_nxt;
	logic             autoclr_r, autoclr_nxt, mode_r, mode_nxt;
	logic [LINES-1:0] out_r, out_nxt, oe_n_r, oe_n_nxt;
	logic             irq_oe_n_r, irq_oe_n_nxt;
	logic [LINES-1:0] edge_hit, src_clr, evt_clr;

	function automatic logic sense_match(input logic [1:0] sense, input logic was, input logic now);
		case (glic_sense_e'(sense))
			SENSE_RISE: sense_match = ~was & now;
			SENSE_FALL: sense_match = was & ~now;
			SENSE_BOTH: sense_match = was ^ now;
			default:    sense_match = 1'b0;
		endcase
	endfunction

	function automatic logic is_wr(input glic_req_s r, input logic [7:0] ofs);
		is_wr = r.wr && r.addr == ofs;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	glic_i2c_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_i2c (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.sda_o      (sda_o),
		.sda_oe_n_o (sda_oe_n_o),
		.req_o      (req),
		.rdata_i    (rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// read mux follows the live pointer so the slave can latch the byte on its decision edge
	always_comb
	begin
		case (req.ptr)
			`GLIC_OFS_DIR_B:    rdata = dir_r[15:8];
			`GLIC_OFS_DIR_A:    rdata = dir_r[7:0];
			`GLIC_OFS_PULL_B:   rdata = pull_r[15:8];
			`GLIC_OFS_PULL_A:   rdata = pull_r[7:0];
			`GLIC_OFS_MASK_B:   rdata = mask_r[15:8];
			`GLIC_OFS_MASK_A:   rdata = mask_r[7:0];
			`GLIC_OFS_SENSE_HB: rdata = sense_r[31:24];
			`GLIC_OFS_SENSE_LB: rdata = sense_r[23:16];
			`GLIC_OFS_SENSE_HA: rdata = sense_r[15:8];
			`GLIC_OFS_SENSE_LA: rdata = sense_r[7:0];
			`GLIC_OFS_SRC_B:    rdata = src_r[15:8];
			`GLIC_OFS_SRC_A:    rdata = src_r[7:0];
			`GLIC_OFS_EVT_B:    rdata = evt_r[15:8];
			`GLIC_OFS_EVT_A:    rdata = evt_r[7:0];
			`GLIC_OFS_DATA_B:   rdata = pad_in_i[15:8];
			`GLIC_OFS_DATA_A:   rdata = pad_in_i[7:0];
			`GLIC_OFS_MODE:     rdata = {7'h00, mode_r};
			`GLIC_OFS_LUT4_A:   rdata = lut4_r;
			`GLIC_OFS_ADV:      rdata = {5'h00, autoclr_r, 2'h0};
			default:            rdata = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_comb
	begin
		dir_nxt     = dir_r;
		pull_nxt    = pull_r;
		mask_nxt    = mask_r;
		data_nxt    = data_r;
		sense_nxt   = sense_r;
		lut4_nxt    = lut4_r;
		mode_nxt    = mode_r;
		autoclr_nxt = autoclr_r;
		if (req.wr)
		begin
			case (req.addr)
				`GLIC_OFS_DIR_B:    dir_nxt[15:8]    = req.data;
				`GLIC_OFS_DIR_A:    dir_nxt[7:0]     = req.data;
				`GLIC_OFS_PULL_B:   pull_nxt[15:8]   = req.data;
				`GLIC_OFS_PULL_A:   pull_nxt[7:0]    = req.data;
				`GLIC_OFS_MASK_B:   mask_nxt[15:8]   = req.data;
				`GLIC_OFS_MASK_A:   mask_nxt[7:0]    = req.data;
				`GLIC_OFS_SENSE_HB: sense_nxt[31:24] = req.data;
				`GLIC_OFS_SENSE_LB: sense_nxt[23:16] = req.data;
				`GLIC_OFS_SENSE_HA: sense_nxt[15:8]  = req.data;
				`GLIC_OFS_SENSE_LA: sense_nxt[7:0]   = req.data;
				`GLIC_OFS_DATA_B:   data_nxt[15:8]   = req.data;
				`GLIC_OFS_DATA_A:   data_nxt[7:0]    = req.data;
				`GLIC_OFS_MODE:     mode_nxt         = req.data[`GLIC_MODE_LOW_A];
				`GLIC_OFS_LUT4_A:   lut4_nxt         = req.data;
				// reserved bits are not stored and read back as zero
				`GLIC_OFS_ADV:      autoclr_nxt      = req.data[`GLIC_ADV_AUTOCLR];
				default:            dir_nxt          = dir_r;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			dir_r     <= `GLIC_RST_DIR;
			pull_r    <= `GLIC_RST_ZERO16;
			mask_r    <= `GLIC_RST_MASK;
			data_r    <= `GLIC_RST_ZERO16;
			sense_r   <= `GLIC_RST_ZERO32;
			lut4_r    <= `GLIC_RST_ZERO8;
			mode_r    <= 1'b0;
			autoclr_r <= 1'b0;
		end
		else
		begin
			dir_r     <= dir_nxt;
			pull_r    <= pull_nxt;
			mask_r    <= mask_nxt;
			data_r    <= data_nxt;
			sense_r   <= sense_nxt;
			lut4_r    <= lut4_nxt;
			mode_r    <= mode_nxt;
			autoclr_r <= autoclr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// edge detection and sticky flags; a new edge wins over a clear in the same cycle
	always_comb
	begin
		prev_nxt = pad_in_i;
		for (int i = 0; i < LINES; i++)
			edge_hit[i] = sense_match(sense_r[2*i+:2], prev_r[i], pad_in_i[i]);
		evt_clr = '0;
		src_clr = '0;
		if (is_wr(req, `GLIC_OFS_EVT_B) || is_wr(req, `GLIC_OFS_SRC_B))
			src_clr[15:8] = req.data;
		if (is_wr(req, `GLIC_OFS_EVT_A) || is_wr(req, `GLIC_OFS_SRC_A))
			src_clr[7:0] = req.data;
		if (is_wr(req, `GLIC_OFS_EVT_B))
			evt_clr[15:8] = req.data;
		if (is_wr(req, `GLIC_OFS_EVT_A))
			evt_clr[7:0] = req.data;
		if (autoclr_r && req.rd && (req.addr == `GLIC_OFS_DATA_A || req.addr == `GLIC_OFS_DATA_B))
			src_clr = '1;
		src_nxt      = (src_r & ~src_clr) | (edge_hit & ~mask_r);
		evt_nxt      = (evt_r & ~evt_clr) | edge_hit;
		irq_oe_n_nxt = ~|src_nxt;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			// start from the live levels so no false edge follows reset
			prev_r     <= pad_in_i;
			src_r      <= `GLIC_RST_ZERO16;
			evt_r      <= `GLIC_RST_ZERO16;
			irq_oe_n_r <= 1'b1;
		end
		else
		begin
			prev_r     <= prev_nxt;
			src_r      <= src_nxt;
			evt_r      <= evt_nxt;
			irq_oe_n_r <= irq_oe_n_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pad drive; the table output costs one cycle of latency after lines 2:0 move
	always_comb
	begin
		out_nxt  = data_r;
		oe_n_nxt = dir_r;
		if (mode_r)
		begin
			out_nxt[`GLIC_LUT_LINE]  = lut4_r[pad_in_i[2:0]];
			oe_n_nxt[`GLIC_LUT_LINE] = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			out_r  <= `GLIC_RST_ZERO16;
			oe_n_r <= `GLIC_RST_DIR;
		end
		else
		begin
			out_r  <= out_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign pad_out_o        = out_r;
	assign pad_oe_n_o       = oe_n_r;
	assign pull_en_o        = pull_r;
	assign irq_out_n_o      = 1'b0;
	assign irq_out_n_oe_n_o = irq_oe_n_r;

endmodule

// [logic/glic_params.svh]
/*
 Register offsets, field positions, reset values and addressing constants of the GPIO table and interrupt
 controller. Assumes inclusion by bare name from the design files.
*/
`ifndef GLIC_PARAMS_SVH
`define GLIC_PARAMS_SVH

`define GLIC_OFS_DIR_B     8'h00
`define GLIC_OFS_DIR_A     8'h01
`define GLIC_OFS_PULL_B    8'h02
`define GLIC_OFS_PULL_A    8'h03
`define GLIC_OFS_MASK_B    8'h04
`define GLIC_OFS_MASK_A    8'h05
`define GLIC_OFS_SENSE_HB  8'h06
`define GLIC_OFS_SENSE_LB  8'h07
`define GLIC_OFS_SENSE_HA  8'h08
`define GLIC_OFS_SENSE_LA  8'h09
`define GLIC_OFS_SRC_B     8'h0A
`define GLIC_OFS_SRC_A     8'h0B
`define GLIC_OFS_EVT_B     8'h0C
`define GLIC_OFS_EVT_A     8'h0D
`define GLIC_OFS_DATA_B    8'h0E
`define GLIC_OFS_DATA_A    8'h0F
`define GLIC_OFS_MODE      8'h10
`define GLIC_OFS_LUT4_A    8'h2B
`define GLIC_OFS_ADV       8'hAD

`define GLIC_RST_DIR       16'hFFFF
`define GLIC_RST_MASK      16'hFFFF
`define GLIC_RST_ZERO8     8'h00
`define GLIC_RST_ZERO16    16'h0000
`define GLIC_RST_ZERO32    32'h0000_0000

`define GLIC_ADV_AUTOCLR   2
`define GLIC_MODE_LOW_A    0
`define GLIC_LUT_LINE      4
`define GLIC_I2C_ADDR      7'h20
`define GLIC_BITS_PER_BYTE 4'h8

`endif

// [logic/glic_pkg.sv]
/*
 Types shared by the I2C slave and the controller core. Assumes nothing beyond a SystemVerilog compiler.
*/
package glic_pkg;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'h0,
		ST_ADDR  = 3'h1,
		ST_ACK_A = 3'h3,
		ST_WRITE = 3'h2,
		ST_ACK_W = 3'h6,
		ST_READ  = 3'h7,
		ST_ACK_R = 3'h5
	} glic_i2c_st_e;

	typedef enum logic [1:0]
	{
		SENSE_NONE = 2'h0,
		SENSE_RISE = 2'h1,
		SENSE_FALL = 2'h2,
		SENSE_BOTH = 2'h3
	} glic_sense_e;

	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] data;
		logic [7:0] ptr;
	} glic_req_s;

endpackage

// [logic/glic_i2c_slave.sv]
/*
 I2C slave: address match, register pointer byte, auto-incrementing writes and reads.
 Assumes scl_i and sda_i are already synchronous to clk_i and far slower than it.
*/
`timescale 1ns/1ps
`include "glic_params.svh"

module glic_i2c_slave #(
	parameter logic [6:0] DEV_ADDR = `GLIC_I2C_ADDR
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             scl_i,
	input  wire logic             sda_i,
	output logic                  sda_o,
	output logic                  sda_oe_n_o,
	output glic_pkg::glic_req_s   req_o,
	input  wire logic [7:0]       rdata_i
);
	import glic_pkg::*;

	logic         scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;
	glic_i2c_st_e st_r, st_nxt;
	logic [3:0]   cnt_r, cnt_nxt;
	logic [7:0]   sh_r, sh_nxt, ptr_r, ptr_nxt;
	logic         first_r, first_nxt, rw_r, rw_nxt, low_r, low_nxt;
	glic_req_s    req_r, req_nxt;
	logic         start, stop, rise, fall;

	assign start = scl_i & scl_d_r & sda_d_r & ~sda_i;
	assign stop  = scl_i & scl_d_r & ~sda_d_r & sda_i;
	assign rise  = scl_i & ~scl_d_r;
	assign fall  = ~scl_i & scl_d_r;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		scl_d_nxt    = scl_i;
		sda_d_nxt    = sda_i;
		st_nxt       = st_r;
		cnt_nxt      = cnt_r;
		sh_nxt       = sh_r;
		ptr_nxt      = ptr_r;
		first_nxt    = first_r;
		rw_nxt       = rw_r;
		req_nxt      = req_r;
		req_nxt.wr   = 1'b0;
		req_nxt.rd   = 1'b0;
		if (stop)
			st_nxt = ST_IDLE;
		else if (start)
		begin
			st_nxt    = ST_ADDR;
			cnt_nxt   = 4'h0;
			first_nxt = 1'b1;
		end
		else
		begin
			case (st_r)
				ST_ADDR, ST_WRITE:
				begin
					if (rise)
					begin
						sh_nxt  = {sh_r[6:0], sda_i};
						cnt_nxt = cnt_r + 4'h1;
					end
					else if (fall && cnt_r == `GLIC_BITS_PER_BYTE)
					begin
						cnt_nxt = 4'h0;
						if (st_r == ST_ADDR)
						begin
							rw_nxt = sh_r[0];
							st_nxt = (sh_r[7:1] == DEV_ADDR) ? ST_ACK_A : ST_IDLE;
						end
						else
						begin
							st_nxt = ST_ACK_W;
							if (first_r)
							begin
								ptr_nxt   = sh_r;
								first_nxt = 1'b0;
							end
							else
							begin
								req_nxt.wr   = 1'b1;
								req_nxt.addr = ptr_r;
								req_nxt.data = sh_r;
								ptr_nxt      = ptr_r + 8'h01;
							end
						end
					end
				end
				ST_ACK_W:
					if (fall)
						st_nxt = ST_WRITE;
				ST_ACK_A, ST_ACK_R:
				begin
					// master nack ends the read burst
					if (rise && st_r == ST_ACK_R && sda_i)
						st_nxt = ST_IDLE;
					else if (fall)
					begin
						cnt_nxt = 4'h0;
						if (st_r == ST_ACK_A && !rw_r)
							st_nxt = ST_WRITE;
						else
						begin
							st_nxt       = ST_READ;
							sh_nxt       = rdata_i;
							req_nxt.rd   = 1'b1;
							req_nxt.addr = ptr_r;
							ptr_nxt      = ptr_r + 8'h01;
						end
					end
				end
				ST_READ:
				begin
					if (rise)
						cnt_nxt = cnt_r + 4'h1;
					else if (fall)
					begin
						if (cnt_r == `GLIC_BITS_PER_BYTE)
							st_nxt = ST_ACK_R;
						else
							sh_nxt = {sh_r[6:0], 1'b1};
					end
				end
				default:
					st_nxt = ST_IDLE;
			endcase
		end
		req_nxt.ptr = ptr_nxt;
		low_nxt     = (st_nxt == ST_ACK_A) | (st_nxt == ST_ACK_W) | ((st_nxt == ST_READ) & ~sh_nxt[7]);
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			st_r    <= ST_IDLE;
			cnt_r   <= 4'h0;
			sh_r    <= 8'h00;
			ptr_r   <= 8'h00;
			first_r <= 1'b0;
			rw_r    <= 1'b0;
			low_r   <= 1'b0;
			req_r   <= '0;
		end
		else
		begin
			scl_d_r <= scl_d_nxt;
			sda_d_r <= sda_d_nxt;
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			ptr_r   <= ptr_nxt;
			first_r <= first_nxt;
			rw_r    <= rw_nxt;
			low_r   <= low_nxt;
			req_r   <= req_nxt;
		end
	end

	assign sda_o      = 1'b0;
	assign sda_oe_n_o = ~low_r;
	assign req_o      = req_r;

endmodule

// [bench/glic_top_monitor.sv]
/*
 Port-level checker for the GPIO table and interrupt controller, bound into glic_top.
 Assumes one clock domain and that register changes only follow I2C clock activity.
*/
`timescale 1ns/1ps

module glic_top_monitor #(
	parameter int LINES = 16
) (
	input wire logic             clk_i,
	input wire logic             rst_n_i,
	input wire logic             scl_i,
	input wire logic             sda_i,
	input wire logic             sda_o,
	input wire logic             sda_oe_n_o,
	input wire logic [LINES-1:0] pad_in_i,
	input wire logic [LINES-1:0] pad_out_o,
	input wire logic [LINES-1:0] pad_oe_n_o,
	input wire logic [LINES-1:0] pull_en_o,
	input wire logic             irq_out_n_o,
	input wire logic             irq_out_n_oe_n_o
);
	logic [4:0] scl_hist_r;
	logic [4:0] scl_hist_nxt;
	logic       bus_recent;

	// register writes land a few cycles after an SCL fall, so look back five samples
	always_comb scl_hist_nxt = {scl_hist_r[3:0], scl_i};
	always_ff @(posedge clk_i) scl_hist_r <= scl_hist_nxt;
	assign bus_recent = (scl_hist_r != 5'h1F) || !scl_i;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence steady3;
		(scl_i && $stable(pad_in_i[2:0])) [*3];
	endsequence
	sequence bus_quiet4;
		scl_i [*4];
	endsequence

	////////////////////////////////////////////////////////////////////////
	lut_hold_a: assert property (steady3 |-> $stable(pad_out_o[4]))
		else $error("line 4 moved without a select or bus change");
	dir_bus_a: assert property ($changed(pad_oe_n_o) |-> bus_recent)
		else $error("pad drive changed with the bus idle");
	pull_bus_a: assert property ($changed(pull_en_o) |-> bus_recent)
		else $error("pull-up enables changed with the bus idle");
	data_bus_a: assert property ($changed(pad_out_o[3:0]) |-> bus_recent)
		else $error("output latch changed with the bus idle");
	irq_cause_a: assert property ($fell(irq_out_n_oe_n_o) |->
		($past(pad_in_i, 2) != $past(pad_in_i, 3)) || ($past(pad_in_i, 1) != $past(pad_in_i, 2)))
		else $error("interrupt asserted without a pad edge");
	irq_hold_a: assert property (!irq_out_n_oe_n_o ##0 bus_quiet4 |-> !irq_out_n_oe_n_o)
		else $error("interrupt released with the bus idle");
	irq_clear_a: assert property ($rose(irq_out_n_oe_n_o) |-> bus_recent)
		else $error("interrupt released without host access");
	irq_drive_a: assert property (irq_out_n_o == 1'b0 && sda_o == 1'b0)
		else $error("open-drain value not low");
endmodule

bind glic_top glic_top_monitor #(.LINES(LINES)) mon (
	.clk_i            (clk_i),
	.rst_n_i          (rst_n_i),
	.scl_i            (scl_i),
	.sda_i            (sda_i),
	.sda_o            (sda_o),
	.sda_oe_n_o       (sda_oe_n_o),
	.pad_in_i         (pad_in_i),
	.pad_out_o        (pad_out_o),
	.pad_oe_n_o       (pad_oe_n_o),
	.pull_en_o        (pull_en_o),
	.irq_out_n_o      (irq_out_n_o),
	.irq_out_n_oe_n_o (irq_out_n_oe_n_o)
);

// [bench/glic_host_model.sv]
/*
 Behavioural I2C host: register write and read transactions, counts missing acknowledges.
 Assumes the bench resolves SDA as an open-drain line with a pull-up.
*/
`timescale 1ns/1ps
`include "glic_params.svh"

module glic_host_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	int nacks;
	int slow;

	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		nacks = 0;
		slow = 0;
	end

	// lines change just after an edge; slow stretches every phase
	task automatic put(input logic s, input logic l);
		@(posedge clk_i);
		scl_o <= s;
		sda_low_o <= l;
		repeat (3 + slow) @(posedge clk_i);
	endtask
	task automatic wbit(input logic b);
		put(1'b0, sda_low_o);
		put(1'b0, !b);
		put(1'b1, !b);
	endtask
	task automatic rbit(output logic b);
		put(1'b0, sda_low_o);
		put(1'b0, 1'b0);
		put(1'b1, 1'b0);
		b = sda_i;
	endtask
	task automatic wbyte(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) wbit(d[i]);
		rbit(a);
		if (a !== 1'b0) nacks++;
	endtask
	task automatic rbyte(output logic [7:0] d);
		for (int i = 7; i >= 0; i--) rbit(d[i]);
		wbit(1'b1);
	endtask
	task automatic start();
		put(1'b1, 1'b0);
		put(1'b1, 1'b1);
	endtask
	task automatic stop();
		put(1'b0, 1'b1);
		put(1'b1, 1'b1);
		put(1'b1, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		start();
		wbyte({`GLIC_I2C_ADDR, 1'b0});
		wbyte(a);
		wbyte(d);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		start();
		wbyte({`GLIC_I2C_ADDR, 1'b0});
		wbyte(a);
		stop();
		start();
		wbyte({`GLIC_I2C_ADDR, 1'b1});
		rbyte(d);
		stop();
	endtask
endmodule

// [bench/tb.sv]
/*
 Self-checking bench: the host model reaches the registers, the bench drives pad levels and checks pins.
 Assumes the host model and the checker are compiled before it.
*/
`timescale 1ns/1ps
`include "glic_params.svh"

module tb;
	logic        clk_i;
	logic        rst_n_i;
	logic        scl;
	logic        sda_low;
	logic        sda_wire;
	logic        sda_o;
	logic        sda_oe_n_o;
	logic [15:0] pad_in_i;
	logic [15:0] pad_out_o;
	logic [15:0] pad_oe_n_o;
	logic [15:0] pull_en_o;
	logic        irq_out_n_o;
	logic        irq_out_n_oe_n_o;
	logic [7:0]  rd_v;
	int          fails;
	int          compares;

	localparam logic [7:0] lut_pat = 8'h96;

	// open-drain line with pull-up
	assign sda_wire = !sda_low && (sda_oe_n_o !== 1'b0);

	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	glic_top uut (
		.clk_i            (clk_i),
		.rst_n_i          (rst_n_i),
		.scl_i            (scl),
		.sda_i            (sda_wire),
		.sda_o            (sda_o),
		.sda_oe_n_o       (sda_oe_n_o),
		.pad_in_i         (pad_in_i),
		.pad_out_o        (pad_out_o),
		.pad_oe_n_o       (pad_oe_n_o),
		.pull_en_o        (pull_en_o),
		.irq_out_n_o      (irq_out_n_o),
		.irq_out_n_oe_n_o (irq_out_n_oe_n_o)
	);
	glic_host_model host (.clk_i(clk_i), .sda_i(sda_wire), .scl_o(scl), .sda_low_o(sda_low));

	////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (fails == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t pins %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait for the interrupt line; running out ends the run
	task automatic wirq(input logic exp);
		int n;
		n = 0;
		while (irq_out_n_oe_n_o !== exp && n < 200)
		begin
			@(posedge clk_i);
			n++;
		end
		chk16({15'h0, irq_out_n_oe_n_o}, {15'h0, exp});
		if (irq_out_n_oe_n_o !== exp)
			test_done();
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		fails = 0;
		compares = 0;
		rst_n_i <= 1'b0;
		pad_in_i <= 16'hFFFF;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		chk16(pad_oe_n_o, 16'hFFFF);
		chk16(pull_en_o, 16'h0000);
		host.rd(`GLIC_OFS_LUT4_A, rd_v);
		chk8(rd_v, 8'h00);
		host.slow = 4;
		host.rd(`GLIC_OFS_ADV, rd_v);
		chk8(rd_v, 8'h00);
		host.slow = 0;
		host.wr(`GLIC_OFS_PULL_A, 8'hFF);
		host.wr(`GLIC_OFS_PULL_B, 8'hFF);
		chk16(pull_en_o, 16'hFFFF);
		host.wr(`GLIC_OFS_DIR_A, 8'h0F);
		chk16(pad_oe_n_o, 16'hFF0F);
		host.wr(`GLIC_OFS_DIR_A, 8'hFF);
		host.wr(`GLIC_OFS_LUT4_A, lut_pat);
		host.wr(`GLIC_OFS_MODE, 8'h01);
		for (int i = 0; i < 8; i++)
		begin
			pad_in_i[2:0] <= i[2:0];
			repeat (3) @(posedge clk_i);
			chk16({14'h0, pad_oe_n_o[4], pad_out_o[4]}, {14'h0, 1'b0, lut_pat[i]});
		end
		host.wr(`GLIC_OFS_MASK_A, 8'h40);
		host.wr(`GLIC_OFS_SENSE_HA, 8'hAA);
		host.wr(`GLIC_OFS_SENSE_LA, 8'hAA);
		pad_in_i[6] <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk16({15'h0, irq_out_n_oe_n_o}, 16'h0001);
		pad_in_i[5] <= 1'b0;
		wirq(1'b0);
		host.rd(`GLIC_OFS_SRC_A, rd_v);
		chk8(rd_v, 8'h20);
		host.rd(`GLIC_OFS_DATA_A, rd_v);
		chk8(rd_v, 8'h9F);
		chk16({15'h0, irq_out_n_oe_n_o}, 16'h0000);
		pad_in_i[5] <= 1'b1;
		host.wr(`GLIC_OFS_SRC_A, 8'hFF);
		wirq(1'b1);
		repeat (8) @(posedge clk_i);
		chk16({15'h0, irq_out_n_oe_n_o}, 16'h0001);
		host.wr(`GLIC_OFS_ADV, 8'h04);
		host.rd(`GLIC_OFS_ADV, rd_v);
		chk8(rd_v, 8'h04);
		pad_in_i[5] <= 1'b0;
		wirq(1'b0);
		host.rd(`GLIC_OFS_DATA_B, rd_v);
		chk8(rd_v, 8'hFF);
		wirq(1'b1);
		pad_in_i[7] <= 1'b0;
		wirq(1'b0);
		host.rd(`GLIC_OFS_DATA_A, rd_v);
		chk8(rd_v, 8'h1F);
		wirq(1'b1);
		pad_in_i[0] <= 1'b0;
		wirq(1'b0);
		host.rd(`GLIC_OFS_EVT_A, rd_v);
		chk8(rd_v, 8'hE1);
		host.wr(`GLIC_OFS_EVT_A, 8'hFF);
		wirq(1'b1);
		host.rd(`GLIC_OFS_EVT_A, rd_v);
		chk8(rd_v, 8'h00);
		host.wr(`GLIC_OFS_DATA_B, 8'hA5);
		host.wr(`GLIC_OFS_DATA_A, 8'h0A);
		chk8(pad_out_o[15:8], 8'hA5);
		chk8({4'h0, pad_out_o[3:0]}, 8'h0A);
		host.rd(8'h50, rd_v);
		chk8(rd_v, 8'h00);
		chk8(host.nacks[7:0], 8'h00);
		test_done();
	end
endmodule
